/* File: hdl/dmcd_top.sv */
// Display mode command decoder: keeps the partial-mode and inversion flags.
// Assumes the command interface delivers one code per strobe, synchronous to clk,
// and that power-on, hardware and software resets are merged into sys_rst.
//
// What this block does
// - Code 12h or 1200h sets the partial display mode flag.
// - Enter-partial while already partial changes no state.
// - Code 13h or 1300h clears partial mode, the only command that leaves it.
// - Normal-mode while already normal changes no state.
// - Mode switches in either direction cause no visible disturbance.
// - After any reset the device is in normal mode with partial off.
// - Code 20h or 2000h clears inversion and touches nothing else.
// - Code 21h or 2100h sets inversion and touches nothing else.
// - Inversion-off while inversion is off is ignored.
// - Inversion-on while inversion is on is ignored.
// - After any reset inversion is off.
// - All four commands are taken in every awake or asleep state.
`timescale 1ns/100ps
`include "dmcd_consts.svh"
module dmcd_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_strobe,
    input wire logic cmd_wide,
    input wire logic [15:0] cmd_code,
    input wire logic frame_start,
    output logic partial_mode,
    output logic inversion_on,
    output logic mode_changed
);

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    dmcd_cmd_if dec_bus ();

    dmcd_code_decode u_decode (
        .clk(clk),
        .sys_rst(sys_rst),
        .cmd_strobe(cmd_strobe),
        .cmd_wide(cmd_wide),
        .cmd_code(cmd_code),
        .dec(dec_bus)
    );

    // ------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------
    // Requested flags follow commands at once; the exported flags follow them
    // only at a frame boundary so the panel never sees a mid-frame switch.
    logic partial_req_reg;
    logic invert_req_reg;
    logic partial_req_next;
    logic invert_req_next;

    // No sleep, idle or power state enters here: commands act in every state.
    always_comb begin
        partial_req_next = partial_req_reg;
        invert_req_next = invert_req_reg;
        if (dec_bus.valid) begin
            unique case (dec_bus.cmd)
                dmcd_pkg::DMCD_CMD_PARTIAL_ON: partial_req_next = 1'b1;
                dmcd_pkg::DMCD_CMD_NORMAL_ON: partial_req_next = 1'b0;
                dmcd_pkg::DMCD_CMD_INV_OFF: invert_req_next = 1'b0;
                dmcd_pkg::DMCD_CMD_INV_ON: invert_req_next = 1'b1;
                dmcd_pkg::DMCD_CMD_NONE: partial_req_next = partial_req_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            partial_req_reg <= `DMCD_PARTIAL_RST;
        end else begin
            partial_req_reg <= partial_req_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            invert_req_reg <= `DMCD_INVERT_RST;
        end else begin
            invert_req_reg <= invert_req_next;
        end
    end

    // ------------------------------------------------------------
    // Frame-aligned outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            partial_mode <= `DMCD_PARTIAL_RST;
            inversion_on <= `DMCD_INVERT_RST;
            mode_changed <= 1'b0;
        end else begin
            if (frame_start) begin
                partial_mode <= partial_req_reg;
                inversion_on <= invert_req_reg;
            end
            mode_changed <= frame_start && ((partial_req_reg != partial_mode)
                || (invert_req_reg != inversion_on));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_enter_partial;
        dec_bus.valid && dec_bus.cmd == dmcd_pkg::DMCD_CMD_PARTIAL_ON;
    endsequence
    sequence s_enter_normal;
        dec_bus.valid && dec_bus.cmd == dmcd_pkg::DMCD_CMD_NORMAL_ON;
    endsequence
    sequence s_inv_off;
        dec_bus.valid && dec_bus.cmd == dmcd_pkg::DMCD_CMD_INV_OFF;
    endsequence
    sequence s_inv_on;
        dec_bus.valid && dec_bus.cmd == dmcd_pkg::DMCD_CMD_INV_ON;
    endsequence

    a_partial_set: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && !cmd_wide && cmd_code[7:0] == `DMCD_CODE_PARTIAL_ON
        ##1 s_enter_partial |=> partial_req_reg)
        else $error("partial request not set");
    a_partial_idem: assert property (@(posedge clk) disable iff (sys_rst)
        s_enter_partial and partial_req_reg |=> partial_req_reg && $stable(invert_req_reg))
        else $error("repeated partial command changed state");
    a_normal_clear: assert property (@(posedge clk) disable iff (sys_rst)
        s_enter_normal |=> !partial_req_reg && $stable(invert_req_reg))
        else $error("normal command did not clear partial");
    a_normal_idem: assert property (@(posedge clk) disable iff (sys_rst)
        s_enter_normal and !partial_req_reg |=> !partial_req_reg)
        else $error("repeated normal command changed state");
    a_frame_align: assert property (@(posedge clk) disable iff (sys_rst)
        !frame_start |=> $stable(partial_mode) && $stable(inversion_on))
        else $error("output flag changed off a frame boundary");
    a_reset_state: assert property (@(posedge clk)
        sys_rst |=> !partial_mode && !inversion_on && !partial_req_reg && !invert_req_reg)
        else $error("flags not cleared by reset");
    a_inversion_disable_cmd_clear: assert property (@(posedge clk) disable iff (sys_rst)
        s_inv_off |=> !invert_req_reg && $stable(partial_req_reg))
        else $error("inversion off failed or touched partial");
    a_inversion_enable_cmd_set: assert property (@(posedge clk) disable iff (sys_rst)
        s_inv_on |=> invert_req_reg && $stable(partial_req_reg))
        else $error("inversion on failed or touched partial");
    a_inversion_disable_cmd_idem: assert property (@(posedge clk) disable iff (sys_rst)
        s_inv_off and !invert_req_reg |=> !invert_req_reg)
        else $error("repeated inversion off changed state");
    a_inversion_enable_cmd_idem: assert property (@(posedge clk) disable iff (sys_rst)
        s_inv_on and invert_req_reg |=> invert_req_reg)
        else $error("repeated inversion on changed state");
    a_output_follow: assert property (@(posedge clk) disable iff (sys_rst)
        frame_start |=> partial_mode == $past(partial_req_reg)
            && inversion_on == $past(invert_req_reg))
        else $error("outputs did not load at frame start");
    a_no_cmd_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !dec_bus.valid |=> $stable(partial_req_reg) && $stable(invert_req_reg))
        else $error("flags moved without a command");

    // ------------------------------------------------------------
    // Latency, refusal and change-pulse checks
    // ------------------------------------------------------------
    // Own copy of the code table, so these checks do not lean on the
    // decoder function that they are meant to catch out.
    function automatic logic is_mode_code(input logic [7:0] code);
        is_mode_code = (code == `DMCD_CODE_PARTIAL_ON) || (code == `DMCD_CODE_NORMAL_ON)
            || (code == `DMCD_CODE_INV_OFF) || (code == `DMCD_CODE_INV_ON);
    endfunction : is_mode_code

    // Request flags settle a fixed count of edges after the strobe edge
    a_narrow_normal: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && !cmd_wide && cmd_code[7:0] == `DMCD_CODE_NORMAL_ON
        |-> ##`DMCD_UPDATE_LATENCY !partial_req_reg)
        else $error("narrow normal code did not clear partial in time");
    a_narrow_inversion_disable_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && !cmd_wide && cmd_code[7:0] == `DMCD_CODE_INV_OFF
        |-> ##`DMCD_UPDATE_LATENCY !invert_req_reg)
        else $error("narrow inversion off code did not land in time");
    a_narrow_inversion_enable_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && !cmd_wide && cmd_code[7:0] == `DMCD_CODE_INV_ON
        |-> ##`DMCD_UPDATE_LATENCY invert_req_reg)
        else $error("narrow inversion on code did not land in time");
    a_wide_latency: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code == `DMCD_CODE16_PARTIAL_ON
        |-> ##`DMCD_UPDATE_LATENCY partial_req_reg)
        else $error("wide partial code did not land in time");

    // Anything not in the table must leave the handshake quiet
    a_wide_refused: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code[7:0] != 8'h00
        |=> !dec_bus.valid)
        else $error("wide code with nonzero low byte was taken");
    a_unknown_refused: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && !cmd_wide && !is_mode_code(cmd_code[7:0])
        |=> !dec_bus.valid)
        else $error("unknown narrow code was taken");
    a_wide_unknown: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code[7:0] == 8'h00 && !is_mode_code(cmd_code[15:8])
        |=> !dec_bus.valid)
        else $error("unknown wide code was taken");
    a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !cmd_strobe
        |=> !dec_bus.valid)
        else $error("command decoded without a strobe");

    // The change pulse marks exactly the frames at which a flag moved
    a_change_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        mode_changed
        |-> $past(frame_start))
        else $error("change pulse without a frame start");
    a_change_cause: assert property (@(posedge clk) disable iff (sys_rst)
        frame_start && (partial_req_reg != partial_mode || invert_req_reg != inversion_on)
        |=> mode_changed)
        else $error("flag change at frame start gave no pulse");
    a_change_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        frame_start && partial_req_reg == partial_mode && invert_req_reg == inversion_on
        |=> !mode_changed)
        else $error("change pulse at a frame with no flag change");

endmodule : dmcd_top

/* File: hdl/dmcd_consts.svh */
// Constants of the display mode command decoder: command codes and reset values.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef DMCD_CONSTS_SVH
`define DMCD_CONSTS_SVH

// 8-bit command codes
`define DMCD_CODE_PARTIAL_ON 8'h12
`define DMCD_CODE_NORMAL_ON 8'h13
`define DMCD_CODE_INV_OFF 8'h20
`define DMCD_CODE_INV_ON 8'h21
// 16-bit serial command codes
`define DMCD_CODE16_PARTIAL_ON 16'h1200
`define DMCD_CODE16_NORMAL_ON 16'h1300
`define DMCD_CODE16_INV_OFF 16'h2000
`define DMCD_CODE16_INV_ON 16'h2100
// Reset values of the mode flags
`define DMCD_PARTIAL_RST 1'h0
`define DMCD_INVERT_RST 1'h0
// Fixed latency from command strobe to flag update, in cycles
`define DMCD_UPDATE_LATENCY 2

`endif

/* File: hdl/dmcd_pkg.sv */
// Types of the display mode command decoder.
// Assumes nothing of its surroundings.
package dmcd_pkg;

    typedef enum logic [2:0] {
        DMCD_CMD_NONE = 3'b000,
        DMCD_CMD_PARTIAL_ON = 3'b001,
        DMCD_CMD_NORMAL_ON = 3'b010,
        DMCD_CMD_INV_OFF = 3'b011,
        DMCD_CMD_INV_ON = 3'b100
    } dmcd_cmd_t;

endpackage : dmcd_pkg

/* File: hdl/dmcd_cmd_if.sv */
// Decoded command handshake between the code decoder and the mode state.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
interface dmcd_cmd_if;
    logic valid;
    dmcd_pkg::dmcd_cmd_t cmd;

    modport source (output valid, output cmd);
    modport sink (input valid, input cmd);
endinterface : dmcd_cmd_if

/* File: hdl/dmcd_code_decode.sv */
// Code decoder: maps a received command code to one of the four mode commands.
// Assumes the code and its strobe are synchronous to clk.
`timescale 1ns/100ps
`include "dmcd_consts.svh"
module dmcd_code_decode (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_strobe,
    input wire logic cmd_wide,
    input wire logic [15:0] cmd_code,
    dmcd_cmd_if.source dec
);

    // ------------------------------------------------------------
    // Code lookup
    // ------------------------------------------------------------
    // Both serial forms share one table; the wide form must carry zero low byte.
    function automatic dmcd_pkg::dmcd_cmd_t lookup(input logic wide, input logic [15:0] code);
        logic [7:0] key;
        logic ok;
        key = wide ? code[15:8] : code[7:0];
        ok = wide ? (code[7:0] == 8'h00) : 1'b1;
        lookup = dmcd_pkg::DMCD_CMD_NONE;
        if (ok) begin
            unique case (key)
                `DMCD_CODE_PARTIAL_ON: lookup = dmcd_pkg::DMCD_CMD_PARTIAL_ON;
                `DMCD_CODE_NORMAL_ON: lookup = dmcd_pkg::DMCD_CMD_NORMAL_ON;
                `DMCD_CODE_INV_OFF: lookup = dmcd_pkg::DMCD_CMD_INV_OFF;
                `DMCD_CODE_INV_ON: lookup = dmcd_pkg::DMCD_CMD_INV_ON;
                default: lookup = dmcd_pkg::DMCD_CMD_NONE;
            endcase
        end
    endfunction : lookup

    dmcd_pkg::dmcd_cmd_t found;

    always_comb begin
        found = lookup(cmd_wide, cmd_code);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec.valid <= 1'b0;
            dec.cmd <= dmcd_pkg::DMCD_CMD_NONE;
        end else begin
            dec.valid <= cmd_strobe && (found != dmcd_pkg::DMCD_CMD_NONE);
            dec.cmd <= cmd_strobe ? found : dmcd_pkg::DMCD_CMD_NONE;
        end
    end

    a_wide_partial: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code == `DMCD_CODE16_PARTIAL_ON
        |=> dec.valid && dec.cmd == dmcd_pkg::DMCD_CMD_PARTIAL_ON)
        else $error("wide partial code not decoded");
    a_wide_normal: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code == `DMCD_CODE16_NORMAL_ON
        |=> dec.valid && dec.cmd == dmcd_pkg::DMCD_CMD_NORMAL_ON)
        else $error("wide normal code not decoded");
    a_wide_inversion_disable_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code == `DMCD_CODE16_INV_OFF
        |=> dec.valid && dec.cmd == dmcd_pkg::DMCD_CMD_INV_OFF)
        else $error("wide inversion off code not decoded");
    a_wide_inversion_enable_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_strobe && cmd_wide && cmd_code == `DMCD_CODE16_INV_ON
        |=> dec.valid && dec.cmd == dmcd_pkg::DMCD_CMD_INV_ON)
        else $error("wide inversion on code not decoded");

endmodule : dmcd_code_decode

/* File: bench/dmcd_host_model.sv */
// Host model: issues command codes on the strobe, wide-flag and code lines.
// Assumes its tasks are entered just after a rising edge of clk.
`timescale 1ns/100ps
module dmcd_host_model (
    input wire logic clk,
    output logic cmd_strobe,
    output logic cmd_wide,
    output logic [15:0] cmd_code
);
    // ----------------------------------------
    // Command issue
    // ----------------------------------------
    initial begin
        cmd_strobe = 1'h0;
        cmd_wide = 1'h0;
        cmd_code = 16'h0000;
    end

    // Holds the code one full cycle; back-to-back calls keep the strobe up
    task automatic put(input logic wide, input logic [15:0] code);
        cmd_strobe = 1'h1;
        cmd_wide = wide;
        cmd_code = code;
        @(posedge clk);
        #1;
    endtask : put

    // Released code lines carry a changed pattern, never the last value
    task automatic idle();
        cmd_strobe = 1'h0;
        cmd_wide = ~cmd_wide;
        cmd_code = ~cmd_code;
    endtask : idle
endmodule : dmcd_host_model

/* File: bench/tb_dmcd_top.sv */
// Testbench of the display mode command decoder: table of commands, then reset cases.
// Assumes a single 50 MHz clock and the host model on the command lines.
`timescale 1ns/100ps
module tb_dmcd_top;
    typedef struct packed {
        logic wide;
        logic [15:0] code;
        logic p;
        logic i;
        logic chg;
    } dmcd_row_t;

    logic clk;
    logic sys_rst;
    logic frame_start;
    logic cmd_strobe;
    logic cmd_wide;
    logic [15:0] cmd_code;
    logic partial_mode;
    logic inversion_on;
    logic mode_changed;
    int fail_count = 0;
    int num_checks = 0;
    logic exp_p;
    logic exp_i;
    // Sequence walks every flag change and every ignored repeat
    dmcd_row_t rows [12] = '{
        '{1'h0, 16'h0012, 1'h1, 1'h0, 1'h1}, '{1'h1, 16'h1200, 1'h1, 1'h0, 1'h0},
        '{1'h0, 16'h0021, 1'h1, 1'h1, 1'h1}, '{1'h1, 16'h2100, 1'h1, 1'h1, 1'h0},
        '{1'h1, 16'h1300, 1'h0, 1'h1, 1'h1}, '{1'h0, 16'h0013, 1'h0, 1'h1, 1'h0},
        '{1'h1, 16'h2000, 1'h0, 1'h0, 1'h1}, '{1'h0, 16'h0020, 1'h0, 1'h0, 1'h0},
        '{1'h1, 16'h1201, 1'h0, 1'h0, 1'h0}, '{1'h0, 16'hff12, 1'h1, 1'h0, 1'h1},
        '{1'h0, 16'h0055, 1'h1, 1'h0, 1'h0}, '{1'h0, 16'h0013, 1'h0, 1'h0, 1'h1}};

    dmcd_top u_dmcd_top (.clk(clk), .sys_rst(sys_rst), .cmd_strobe(cmd_strobe),
        .cmd_wide(cmd_wide), .cmd_code(cmd_code), .frame_start(frame_start),
        .partial_mode(partial_mode), .inversion_on(inversion_on),
        .mode_changed(mode_changed));
    dmcd_host_model u_dmcd_host_model (.clk(clk), .cmd_strobe(cmd_strobe),
        .cmd_wide(cmd_wide), .cmd_code(cmd_code));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // Frame lands three edges after the strobe edge, once the request is settled
    task automatic frame_and_check(input logic chg);
        step();
        step();
        check({partial_mode, inversion_on}, {exp_p, exp_i});
        frame_start = 1'h1;
        step();
        frame_start = 1'h0;
        check(mode_changed, chg);
    endtask : frame_and_check

    task automatic conclude();
        $display("Checks made: %0d, mismatches: %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Whole sequence needs under 200 cycles
    initial begin
        #40000;
        fail_count++;
        conclude();
    end

    initial begin
        sys_rst = 1'h1;
        frame_start = 1'h0;
        exp_p = 1'h0;
        exp_i = 1'h0;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        check({partial_mode, inversion_on, mode_changed}, 16'h0000);
        foreach (rows[n]) begin
            u_dmcd_host_model.put(rows[n].wide, rows[n].code);
            u_dmcd_host_model.idle();
            frame_and_check(rows[n].chg);
            exp_p = rows[n].p;
            exp_i = rows[n].i;
            check({partial_mode, inversion_on}, {exp_p, exp_i});
            check(mode_changed, rows[n].chg);
            step();
            check(mode_changed, 16'h0000);
            $display("Row %0d done", n);
        end
        // Back-to-back codes: last one wins before the frame
        u_dmcd_host_model.put(1'h0, 16'h0012);
        u_dmcd_host_model.put(1'h1, 16'h1300);
        u_dmcd_host_model.put(1'h0, 16'h0021);
        u_dmcd_host_model.idle();
        frame_and_check(1'h1);
        exp_i = 1'h1;
        check({partial_mode, inversion_on}, {exp_p, exp_i});
        $display("Back-to-back test done");
        // Mid-run reset with both flags set
        u_dmcd_host_model.put(1'h1, 16'h1200);
        u_dmcd_host_model.idle();
        frame_and_check(1'h1);
        check({partial_mode, inversion_on}, 16'h0003);
        sys_rst = 1'h1;
        step();
        step();
        check({partial_mode, inversion_on, mode_changed}, 16'h0000);
        sys_rst = 1'h0;
        step();
        check({partial_mode, inversion_on, mode_changed}, 16'h0000);
        // Requests must be cleared as well: a bare frame after reset moves nothing
        exp_p = 1'h0;
        exp_i = 1'h0;
        frame_and_check(1'h0);
        check({partial_mode, inversion_on}, 16'h0000);
        $display("Reset test done");
        conclude();
    end
endmodule : tb_dmcd_top
